// file: sim/sdf_far_end.sv
// Far end drive model: transport busy per frame, refusal and interrupt on command
`timescale 1ns/1ps
`default_nettype none
module sdf_far_end (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Frame launches and scenario controls
	input  wire logic [3:0] start,
	input  wire logic       nak_en,
	input  wire logic [3:0] irq_go,
	// Transport events back to the block
	output logic      [3:0] tsm_idle,
	output logic      [3:0] tx_nak,
	output logic      [3:0] rx_setup_irq
);
	logic [2:0] cnt [4];
	// Long enough busy time that an abort lands mid-frame
	always_ff @(posedge clk) begin
		for (int p = 0; p < 4; p++) begin
			if (!reset_n) cnt[p] <= 3'h0;
			else if (start[p]) cnt[p] <= 3'h6;
			else if (cnt[p] != 3'h0) cnt[p] <= cnt[p] - 3'h1;
		end
	end
	// Refusal as the frame ends; interrupt frames as the bench asks
	always_ff @(posedge clk) begin
		for (int p = 0; p < 4; p++) begin
			tx_nak[p] <= reset_n & nak_en & (cnt[p] == 3'h1);
			rx_setup_irq[p] <= reset_n & irq_go[p];
		end
	end
	// Idle whenever no frame is in flight
	always_comb begin
		for (int p = 0; p < 4; p++) tsm_idle[p] = (cnt[p] == 3'h0);
	end
endmodule
`default_nettype wire

// file: sim/test_sata_dma_setup_fis_control.sv
// Testbench for the DMA setup frame control and status register
`timescale 1ns/1ps
`default_nettype none
module test_sata_dma_setup_fis_control;
	logic              clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              ide_mode = 1'b0;
	logic              nak_en = 1'b0;
	logic [3:0]        irq_go = 4'h0;
	sdf_pkg::sdf_req_t req = '0;
	logic [31:0]       rdata;
	logic              rvalid;
	logic [3:0]        rx_setup_irq, tx_nak, tsm_idle, abort_req, auto_fpdma, start;
	sdf_pkg::sdf_tx_t  tx_cmd [4];
	logic [31:0]       d;
	int                fails = 0;
	int                n_compared = 0;
	int                cycles = 0;
	assign start = {tx_cmd[3].start, tx_cmd[2].start, tx_cmd[1].start, tx_cmd[0].start};
	sdf_ctrl uut (.clk(clk), .reset_n(reset_n), .ide_mode(ide_mode), .req(req), .rdata(rdata),
		.rvalid(rvalid), .rx_setup_irq(rx_setup_irq), .tx_nak(tx_nak), .tsm_idle(tsm_idle),
		.tx_cmd(tx_cmd), .abort_req(abort_req), .auto_fpdma(auto_fpdma));
	sdf_far_end far (.clk(clk), .reset_n(reset_n), .start(start), .nak_en(nak_en),
		.irq_go(irq_go), .tsm_idle(tsm_idle), .tx_nak(tx_nak), .rx_setup_irq(rx_setup_irq));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, and a ceiling well above the hundred or so cycles the tests need
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write strobe is taken at the edge after it is raised
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk) req <= '{1'b1, 1'b0, a, v};
		@(posedge clk) req <= '0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk) req <= '0;
		#1 chk({31'h0, rvalid}, 32'h1);
		v = rdata;
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Offset maps, unmapped read, auto processing level
	task automatic t_map();
		rd(12'h368, d); chk(d, 32'h0);
		rd(12'h400, d); chk(d, 32'h0);
		wr(12'h568, 32'h0800_0000);
		rd(12'h568, d); chk(d, 32'h0800_0000);
		chk({28'h0, auto_fpdma}, 32'h2);
		@(posedge clk) ide_mode <= 1'b1;
		wr(12'h068, 32'h8000_0000);
		rd(12'h068, d); chk(d, 32'h8000_0000);
		wr(12'h07c, 32'h0000_0077);
		rd(12'h07c, d); chk(d, 32'h0000_0077);
		@(posedge clk) ide_mode <= 1'b0;
		rd(12'h368, d); chk(d, 32'h8000_0000);
		$display("test map done");
	endtask
	// Launch with both directions, parameter words in order
	task automatic t_frame();
		for (int k = 0; k < 5; k++) wr(12'h36c + 12'(4 * k), 32'ha0 + k);
		for (int dr = 0; dr < 2; dr++) begin
			wr(12'h368, {dr[0], 3'h1, 28'h0});
			#1 chk({31'h0, tx_cmd[0].start}, 32'h1);
			chk({31'h0, tx_cmd[0].dir}, {31'h0, dr[0]});
			for (int k = 0; k < 5; k++) chk(tx_cmd[0].params[k*32+:32], 32'ha0 + k);
			repeat (8) @(posedge clk);
			rd(12'h368, d); chk(d, {dr[0], 31'h0});
		end
		rd(12'h37c, d); chk(d, 32'h0000_00a4);
		wr(12'h978, 32'h0000_005a);
		rd(12'h978, d); chk(d, 32'h0000_005a);
		chk(tx_cmd[3].params[3*32+:32], 32'h0000_005a);
		$display("test frame done");
	endtask
	// Refusal and received interrupt frame, sticky until written one
	task automatic t_status();
		@(posedge clk) nak_en <= 1'b1;
		wr(12'h368, 32'h1000_0000);
		repeat (9) @(posedge clk);
		nak_en <= 1'b0;
		rd(12'h368, d); chk(d, 32'h0080_0000);
		wr(12'h368, 32'h0080_0000);
		rd(12'h368, d); chk(d, 32'h0);
		@(posedge clk) irq_go <= 4'h4;
		@(posedge clk) irq_go <= 4'h0;
		repeat (3) @(posedge clk);
		rd(12'h768, d); chk(d, 32'h4000_0000);
		wr(12'h768, 32'h4000_0000);
		rd(12'h768, d); chk(d, 32'h0);
		// Event and clear in one cycle: the event must win
		@(posedge clk) irq_go <= 4'h4;
		fork
			wr(12'h768, 32'h4000_0000);
			@(posedge clk) irq_go <= 4'h0;
		join
		rd(12'h768, d); chk(d, 32'h4000_0000);
		wr(12'h768, 32'h4000_0000);
		rd(12'h768, d); chk(d, 32'h0);
		$display("test status done");
	endtask
	// Abort during a frame holds until transport goes idle
	task automatic t_abort();
		wr(12'h368, 32'h1000_0000);
		wr(12'h368, 32'h0100_0000);
		@(posedge clk) #1 chk({31'h0, abort_req[0]}, 32'h1);
		for (int i = 0; i < 20 && abort_req[0] === 1'b1; i++) @(posedge clk) #1;
		chk({31'h0, abort_req[0]}, 32'h0);
		chk({31'h0, tsm_idle[0]}, 32'h1);
		rd(12'h368, d); chk(d, 32'h0);
		$display("test abort done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		t_map();
		t_frame();
		t_status();
		t_abort();
		final_report();
	end
endmodule
`default_nettype wire

// file: src/sdf_ctrl.sv
// DMA setup frame control and status register with companion parameters
// Functional notes
// - One control register per port, documented offsets
// - Bit 31 drives outgoing frame direction
// - Bit 30 set on received interrupting frame
// - Bit 28 write launches frame, reads zero
// - Bit 27 enables automatic descriptor selection
// - Bit 24 aborts, clears when transport idle
// - Bit 23 set when last frame refused
// - Parameter words from companion registers, ordered
`timescale 1ns/1ps
`default_nettype none
module sdf_ctrl (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Register access, ide_mode selects offset map
	input  wire logic              ide_mode,
	input  wire sdf_pkg::sdf_req_t req,
	output logic [31:0]            rdata,
	output logic                   rvalid,
	// Transport events, same clock
	input  wire logic [3:0]        rx_setup_irq,
	input  wire logic [3:0]        tx_nak,
	input  wire logic [3:0]        tsm_idle,
	// Per-port transport controls
	output sdf_pkg::sdf_tx_t       tx_cmd [4],
	output logic [3:0]             abort_req,
	output logic [3:0]             auto_fpdma
);
	////////////////////////////////////////////////////////////////
	// Port decode shared by read and write paths
	function automatic logic [2:0] ctrl_port(input logic [11:0] a, input logic ide);
		ctrl_port = 3'h4;
		if (ide) begin
			if (a == sdf_pkg::DSF_CTRL_IDE_OFS) ctrl_port = 3'h0;
		end else begin
			unique case (a)
				sdf_pkg::DSF_CTRL_P0_OFS: ctrl_port = 3'h0;
				sdf_pkg::DSF_CTRL_P1_OFS: ctrl_port = 3'h1;
				sdf_pkg::DSF_CTRL_P2_OFS: ctrl_port = 3'h2;
				sdf_pkg::DSF_CTRL_P3_OFS: ctrl_port = 3'h3;
				default: ctrl_port = 3'h4;
			endcase
		end
	endfunction

	// Parameter decode: port in [4:3], word index in [2:0], all ones when unmapped
	function automatic logic [5:0] param_sel(input logic [11:0] a, input logic ide);
		logic [11:0] rel;
		logic [1:0]  p;
		logic        hit;
		param_sel = 6'h3f;
		p = 2'h0;
		rel = 12'hfff;
		hit = 1'b0;
		// Ports differ only in the high nibble; the low byte map is shared
		if (ide) begin
			if (a[11:8] == sdf_pkg::DSF_CTRL_IDE_OFS[11:8]) rel = {4'h0, a[7:0]};
		end else begin
			hit = 1'b1;
			unique case (a[11:8])
				sdf_pkg::DSF_CTRL_P0_OFS[11:8]: p = 2'h0;
				sdf_pkg::DSF_CTRL_P1_OFS[11:8]: p = 2'h1;
				sdf_pkg::DSF_CTRL_P2_OFS[11:8]: p = 2'h2;
				sdf_pkg::DSF_CTRL_P3_OFS[11:8]: p = 2'h3;
				default: hit = 1'b0;
			endcase
			if (hit) rel = {4'h0, a[7:0]};
		end
		if (rel >= sdf_pkg::BUF_ID_LO_OFS && rel <= sdf_pkg::XFER_COUNT_OFS &&
		    rel[1:0] == 2'h0)
			param_sel = {1'b0, p, 3'((rel - sdf_pkg::BUF_ID_LO_OFS) >> 2)};
	endfunction

	logic [2:0] wport;
	logic [5:0] wsel;
	always_comb begin
		wport = ctrl_port(req.addr, ide_mode);
		wsel  = param_sel(req.addr, ide_mode);
	end

	////////////////////////////////////////////////////////////////
	logic [31:0] param_reg [4][5];
	logic [3:0]  dir_reg, irq_reg, auto_reg, abort_reg, nak_reg;

	genvar g;
	generate
		for (g = 0; g < sdf_pkg::PORT_COUNT; g++) begin : g_port
			// Software-owned control bits
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					dir_reg[g]  <= 1'b0;
					auto_reg[g] <= 1'b0;
				end else if (req.wr && wport == 3'(g)) begin
					dir_reg[g]  <= req.wdata[sdf_pkg::DIR_BIT];
					auto_reg[g] <= req.wdata[sdf_pkg::AUTO_BIT];
				end
			end
			// Sticky status, hardware set beats write-one clear
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					irq_reg[g] <= 1'b0;
					nak_reg[g] <= 1'b0;
				end else begin
					if (rx_setup_irq[g])
						irq_reg[g] <= 1'b1;
					else if (req.wr && wport == 3'(g) && req.wdata[sdf_pkg::RX_IRQ_BIT])
						irq_reg[g] <= 1'b0;
					if (tx_nak[g])
						nak_reg[g] <= 1'b1;
					else if (req.wr && wport == 3'(g) && req.wdata[sdf_pkg::NAK_BIT])
						nak_reg[g] <= 1'b0;
				end
			end
			// Abort holds until the transport reports idle
			always_ff @(posedge clk) begin
				if (!reset_n)
					abort_reg[g] <= 1'b0;
				else if (req.wr && wport == 3'(g) && req.wdata[sdf_pkg::ABORT_BIT])
					abort_reg[g] <= 1'b1;
				else if (abort_reg[g] && tsm_idle[g])
					abort_reg[g] <= 1'b0;
			end
			// Start pulse and frame contents
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					tx_cmd[g] <= '0;
				end else begin
					tx_cmd[g].start <= req.wr && wport == 3'(g) &&
					                   req.wdata[sdf_pkg::START_BIT];
					tx_cmd[g].dir   <= (req.wr && wport == 3'(g)) ?
					                   req.wdata[sdf_pkg::DIR_BIT] : dir_reg[g];
					for (int k = 0; k < sdf_pkg::PARAM_COUNT; k++)
						tx_cmd[g].params[k*32 +: 32] <= param_reg[g][k];
				end
			end
			// Parameter words
			for (genvar k = 0; k < sdf_pkg::PARAM_COUNT; k++) begin : g_prm
				always_ff @(posedge clk) begin
					if (!reset_n)
						param_reg[g][k] <= sdf_pkg::CTRL_RESET;
					else if (req.wr && wsel == {1'b0, 2'(g), 3'(k)})
						param_reg[g][k] <= req.wdata;
				end
			end
		end
	endgenerate

	// Outputs toward transport
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			abort_req  <= 4'h0;
			auto_fpdma <= 4'h0;
		end else begin
			abort_req  <= abort_reg;
			auto_fpdma <= auto_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path, one cycle latency; start bit reads zero, unmapped reads zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata  <= 32'h0000_0000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			rdata  <= 32'h0000_0000;
			if (req.rd && wport != 3'h4) begin
				rdata[sdf_pkg::DIR_BIT]    <= dir_reg[wport[1:0]];
				rdata[sdf_pkg::RX_IRQ_BIT] <= irq_reg[wport[1:0]];
				rdata[sdf_pkg::AUTO_BIT]   <= auto_reg[wport[1:0]];
				rdata[sdf_pkg::ABORT_BIT]  <= abort_reg[wport[1:0]];
				rdata[sdf_pkg::NAK_BIT]    <= nak_reg[wport[1:0]];
			end else if (req.rd && !wsel[5])
				rdata <= param_reg[wsel[4:3]][wsel[2:0]];
		end
	end

	////////////////////////////////////////////////////////////////
	// Assertions
	AST_START_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
		tx_cmd[0].start |=> !tx_cmd[0].start || $past(req.wr))
		else $error("start pulse held without a write");
	AST_IRQ_SET: assert property (@(posedge clk) disable iff (!reset_n)
		rx_setup_irq[2] |=> irq_reg[2])
		else $error("receive interrupt status not set");
	AST_NAK_SET: assert property (@(posedge clk) disable iff (!reset_n)
		tx_nak[0] |=> nak_reg[0])
		else $error("refusal status not set");
	AST_ABORT_CLR: assert property (@(posedge clk) disable iff (!reset_n)
		abort_reg[0] && tsm_idle[0] && !req.wr |=> !abort_reg[0])
		else $error("abort did not clear on idle");
	AST_ABORT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
		abort_reg[0] && !tsm_idle[0] |=> abort_reg[0] ##1 abort_req[0])
		else $error("abort dropped before idle");
	AST_AUTO_OUT: assert property (@(posedge clk) disable iff (!reset_n)
		auto_reg[1] |=> auto_fpdma[1])
		else $error("auto processing not driven");
	AST_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
		irq_reg[2] && !req.wr |=> irq_reg[2])
		else $error("status cleared without a write");
	// Parameter words may carry bit 28, so only control reads are judged
	AST_START_READ: assert property (@(posedge clk) disable iff (!reset_n)
		rvalid && $past(wport != 3'h4) |-> !rdata[sdf_pkg::START_BIT])
		else $error("start bit read as one");
	AST_DIR_FOLLOW: assert property (@(posedge clk) disable iff (!reset_n)
		req.wr && wport == 3'h0 |=> tx_cmd[0].dir == $past(req.wdata[sdf_pkg::DIR_BIT]))
		else $error("direction bit not carried to frame");
	AST_RD_VALID: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd |=> rvalid)
		else $error("read not answered");
	AST_NAK_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
		nak_reg[0] && !req.wr |=> nak_reg[0])
		else $error("refusal status cleared without a write");
	// Word lands in the register, then in the frame one cycle later
	AST_PARAM_OUT: assert property (@(posedge clk) disable iff (!reset_n)
		req.wr && wsel == 6'h04 |=> ##1 tx_cmd[0].params[4*32 +: 32] == $past(req.wdata, 2))
		else $error("transfer count word not carried to frame");
endmodule
`default_nettype wire

// file: src/sdf_pkg.sv
// Package for the DMA setup frame control and status register block
package sdf_pkg;
	// Register offsets: IDE mode, then ports 0 to 3 in direct port access mode
	localparam logic [11:0] DSF_CTRL_IDE_OFS = 12'h068;
	localparam logic [11:0] DSF_CTRL_P0_OFS  = 12'h368;
	localparam logic [11:0] DSF_CTRL_P1_OFS  = 12'h568;
	localparam logic [11:0] DSF_CTRL_P2_OFS  = 12'h768;
	localparam logic [11:0] DSF_CTRL_P3_OFS  = 12'h968;
	// Companion parameter registers, in frame word order
	localparam logic [11:0] BUF_ID_LO_OFS    = 12'h06c;
	localparam logic [11:0] BUF_ID_HI_OFS    = 12'h070;
	localparam logic [11:0] RSVD_DW_OFS      = 12'h074;
	localparam logic [11:0] BUF_OFFSET_OFS   = 12'h078;
	localparam logic [11:0] XFER_COUNT_OFS   = 12'h07c;
	// Field positions
	localparam int DIR_BIT      = 31;
	localparam int RX_IRQ_BIT   = 30;
	localparam int START_BIT    = 28;
	localparam int AUTO_BIT     = 27;
	localparam int ABORT_BIT    = 24;
	localparam int NAK_BIT      = 23;
	localparam int PORT_COUNT   = 4;
	localparam int PARAM_COUNT  = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} sdf_req_t;

	// Outgoing setup frame command
	typedef struct packed {
		logic        start;
		logic        dir;
		logic [PARAM_COUNT*32-1:0] params;
	} sdf_tx_t;
endpackage
